/* verilog/cbh_params.svh */
/*
 * constants of the card bridge header slice: config byte offsets,
 * field positions, fixed read values and reset values.
 * assumes inclusion by bare name from every design file that needs it.
 */
`ifndef CBH_PARAMS_SVH
`define CBH_PARAMS_SVH

// ****************************************************************
// config space byte offsets
// ****************************************************************
`define CBH_OFS_CACHE_LINE      8'h0c
`define CBH_OFS_LATENCY         8'h0d
`define CBH_OFS_HEADER_TYPE     8'h0e
`define CBH_OFS_SELF_TEST       8'h0f
`define CBH_OFS_SOCKET_BASE     8'h10
`define CBH_OFS_CAP_POINTER     8'h14
`define CBH_OFS_CARD_STATUS     8'h16
`define CBH_OFS_EXT_AREA        8'h80

// ****************************************************************
// fixed read values
// ****************************************************************
`define CBH_HEADER_TYPE_VAL     8'h82
`define CBH_SELF_TEST_VAL       8'h00
`define CBH_CAP_POINTER_VAL     8'ha0
`define CBH_PM_DWORD0           8'ha0
`define CBH_PM_DWORD1           8'ha4
`define CBH_SELECT_TIMING_VAL   2'h1
`define CBH_BASE_MASK           32'hfffff000

// ****************************************************************
// window layout
// ****************************************************************
`define CBH_WIN_SOCKET_OFS      12'h000
`define CBH_WIN_LEGACY_OFS      12'h800

// ****************************************************************
// card side status bit positions
// ****************************************************************
`define CBH_ST_PARITY           15
`define CBH_ST_SYS_ERR          14
`define CBH_ST_MABORT           13
`define CBH_ST_TABORT_RX        12
`define CBH_ST_TABORT_TX        11
`define CBH_ST_TIMING_HI        10
`define CBH_ST_TIMING_LO        9
`define CBH_ST_DATA_PAR         8

// ****************************************************************
// reset values
// ****************************************************************
`define CBH_LATENCY_RST         8'h00
`define CBH_SOCKET_BASE_RST     32'h00000000
`define CBH_PIN_IDLE            2'h3

`endif

/* verilog/cbh_pkg.sv */
/*
 * types of the card bridge header slice: config request carrier,
 * card event carrier and latency timer states.
 * assumes nothing beyond a systemverilog compiler.
 */
package cbh_pkg;

    // ****************************************************************
    // config access carried from the host config cycle decoder
    // ****************************************************************
    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cbh_cfg_req_t;

    // ****************************************************************
    // one-cycle card bus events from the card side engine
    // ****************************************************************
    typedef struct packed {
        logic addr_perr;
        logic data_perr;
        logic master_abort;
        logic target_abort_rx;
        logic target_abort_tx;
        logic cperr;
        logic master_dphase;
    } cbh_card_evt_t;

    // ****************************************************************
    // primary latency timer states
    // ****************************************************************
    typedef enum logic [1:0] {
        CBH_LAT_IDLE,
        CBH_LAT_COUNT,
        CBH_LAT_EXPIRED
    } cbh_lat_state_t;

endpackage : cbh_pkg

/* verilog/cbh_pin_sync.sv */
/*
 * three stage synchroniser for asynchronous pins; the output moves only
 * when stages two and three agree.
 * assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/1ps
`include "cbh_params.svh"

module cbh_pin_sync (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_out
);

    logic [1:0] stage1_reg;
    logic [1:0] stage2_reg;
    logic [1:0] stage3_reg;
    logic [1:0] agree;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_bit
            assign agree[gi] = (stage2_reg[gi] == stage3_reg[gi]);

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_reg[gi] <= 1'b1;
                    stage2_reg[gi] <= 1'b1;
                    stage3_reg[gi] <= 1'b1;
                    pin_out[gi]    <= 1'b1;
                end else begin
                    stage1_reg[gi] <= pin_in[gi];
                    stage2_reg[gi] <= stage1_reg[gi];
                    stage3_reg[gi] <= stage2_reg[gi];
                    if (agree[gi]) begin
                        pin_out[gi] <= stage3_reg[gi];
                    end
                end
            end
        end
    endgenerate

endmodule : cbh_pin_sync

/* verilog/cbh_cfg_regs.sv */
/*
 * card bridge config header slice, offsets 0dh to 17h: primary latency
 * timer, fixed header bytes, socket window base and decode, capability
 * pointer and card side status flags.
 * assumes a host config decoder presenting one-cycle requests on the
 * system clock, card engine events on the same clock, and GNT_N and
 * CSERR_N arriving as raw pins.
 */
`timescale 1ns/1ps
`include "cbh_params.svh"

//  Operation
// - latency counter starts at zero on frame, counts per clock, expires at value
// - expired transaction still running ends once grant is deasserted
// - header type byte always reads 82h, writes ignored
// - bytes 00h-7Fh are the header, 80h-FFh the extension area
// - self-test byte always reads zero, writes ignored
// - socket base bits 31-12 read/write, bits 11-0 read zero
// - writing all ones to socket base reads back FFFFF000h
// - window decodes socket registers from 000h and legacy registers from 800h
// - capability pointer is read-only and returns A0h
// - clearable status flags clear on written one, zero leaves them
// - status bit 15 sets on card address or data parity error
// - status bit 14 sets on card system error; device never drives it
// - status bit 13 sets on master abort of own card cycle
// - status bit 12 sets on target abort received for own cycle
// - status bit 11 sets when device target-aborts a card transaction
// - status bits 10-9 hardwired to 01b, medium select timing
// - status bit 8 sets on card parity error as master with response enabled
// - status bits 7-0 read zero
module cbh_cfg_regs (
    input  wire logic                  SYS_CLK,
    input  wire logic                  ARST_N,
    input  wire cbh_pkg::cbh_cfg_req_t CFG_IN,
    input  wire cbh_pkg::cbh_card_evt_t CARD_EVT,
    input  wire logic                  CSERR_N,
    input  wire logic                  GNT_N,
    input  wire logic                  INIT_FRAME_START,
    input  wire logic                  INIT_XFER_ACTIVE,
    input  wire logic                  PARITY_RESP_EN,
    input  wire logic                  MEM_VALID,
    input  wire logic [31:0]           MEM_ADDR,
    output logic                       CFG_ACK,
    output logic [31:0]                CFG_RDATA,
    output logic                       CFG_EXT_HIT,
    output logic                       LAT_EXPIRED,
    output logic                       INIT_TERMINATE,
    output logic                       SOCK_HIT,
    output logic                       LEGACY_HIT,
    output logic [10:0]                WIN_OFFSET
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] pins_sync;
    logic       gnt_deasserted;
    logic       cserr_seen;

    cbh_pin_sync u_pin_sync (
        .clk     (SYS_CLK),
        .arst_n  (ARST_N),
        .pin_in  ({CSERR_N, GNT_N}),
        .pin_out (pins_sync)
    );

    assign gnt_deasserted = pins_sync[0];
    assign cserr_seen     = ~pins_sync[1];

    // ****************************************************************
    // config access decode
    // ****************************************************************
    logic       cfg_rd;
    logic       cfg_wr;
    logic       hit_ext;
    logic       hit_lat_dw;
    logic       hit_base_dw;
    logic       hit_stat_dw;
    logic [5:0] dw_index;
    logic [5:0] dw_lat;
    logic [5:0] dw_base;
    logic [5:0] dw_stat;

    // dword indices of the three dwords held in this slice
    assign dw_lat      = 6'(`CBH_OFS_LATENCY >> 2);
    assign dw_base     = 6'(`CBH_OFS_SOCKET_BASE >> 2);
    assign dw_stat     = 6'(`CBH_OFS_CAP_POINTER >> 2);
    assign dw_index    = CFG_IN.addr[7:2];
    assign cfg_rd      = CFG_IN.req & ~CFG_IN.we;
    assign cfg_wr      = CFG_IN.req & CFG_IN.we;
    assign hit_ext     = CFG_IN.addr[7];
    assign hit_lat_dw  = ~hit_ext & (dw_index == dw_lat);
    assign hit_base_dw = ~hit_ext & (dw_index == dw_base);
    assign hit_stat_dw = ~hit_ext & (dw_index == dw_stat);

    // ****************************************************************
    // primary latency count register
    // ****************************************************************
    logic [7:0] latency_reg;
    logic [7:0] latency_next;
    logic       lat_wr;

    // header type and self-test lanes have no storage, so writes vanish
    assign lat_wr       = cfg_wr & hit_lat_dw & CFG_IN.be[1];
    assign latency_next = lat_wr ? CFG_IN.wdata[15:8] : latency_reg;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            latency_reg <= `CBH_LATENCY_RST;
        end else begin
            latency_reg <= latency_next;
        end
    end

    // ****************************************************************
    // socket window base register
    // ****************************************************************
    logic [31:0] base_reg;
    logic [31:0] base_next;
    logic [31:0] base_wmask;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_base_lane
            assign base_wmask[gb*8 +: 8] = {8{cfg_wr & hit_base_dw & CFG_IN.be[gb]}};
        end
    endgenerate

    // low twelve bits never store, so an all-ones probe returns fffff000h
    assign base_next = ((base_reg & ~base_wmask) | (CFG_IN.wdata & base_wmask))
                       & `CBH_BASE_MASK;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            base_reg <= `CBH_SOCKET_BASE_RST;
        end else begin
            base_reg <= base_next;
        end
    end

    // ****************************************************************
    // card side status flags
    // ****************************************************************
    logic [15:0] status_set;
    logic [15:0] status_clr;
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [15:0] status_view;
    logic        stat_lo_wr;
    logic        stat_hi_wr;

    assign stat_lo_wr = cfg_wr & hit_stat_dw & CFG_IN.be[2];
    assign stat_hi_wr = cfg_wr & hit_stat_dw & CFG_IN.be[3];

    always_comb begin
        status_set = 16'h0000;
        status_set[`CBH_ST_PARITY]    = CARD_EVT.addr_perr | CARD_EVT.data_perr;
        status_set[`CBH_ST_SYS_ERR]   = cserr_seen;
        status_set[`CBH_ST_MABORT]    = CARD_EVT.master_abort;
        status_set[`CBH_ST_TABORT_RX] = CARD_EVT.target_abort_rx;
        status_set[`CBH_ST_TABORT_TX] = CARD_EVT.target_abort_tx;
        status_set[`CBH_ST_DATA_PAR]  = CARD_EVT.cperr & CARD_EVT.master_dphase
                                        & PARITY_RESP_EN;
    end

    // write-one-to-clear per byte lane; a set in the same cycle wins
    assign status_clr  = {{8{stat_hi_wr}} & CFG_IN.wdata[31:24],
                          {8{stat_lo_wr}} & CFG_IN.wdata[23:16]};
    assign status_next = ((status_reg & ~status_clr) | status_set) & 16'hf900;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
        end
    end

    always_comb begin
        status_view = status_reg;
        status_view[`CBH_ST_TIMING_HI:`CBH_ST_TIMING_LO] = `CBH_SELECT_TIMING_VAL;
        status_view[7:0] = 8'h00;
    end

    // ****************************************************************
    // config read data
    // ****************************************************************
    logic [31:0] rd_lat_dw;
    logic [31:0] rd_stat_dw;
    logic [31:0] rd_mux;

    assign rd_lat_dw  = {`CBH_SELF_TEST_VAL, `CBH_HEADER_TYPE_VAL,
                         latency_reg, 8'h00};
    assign rd_stat_dw = {status_view, 8'h00, `CBH_CAP_POINTER_VAL};

    // the extension area and other header dwords belong elsewhere: zero here
    assign rd_mux = hit_lat_dw  ? rd_lat_dw  :
                    hit_base_dw ? base_reg   :
                    hit_stat_dw ? rd_stat_dw : 32'h00000000;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CFG_ACK     <= 1'b0;
            CFG_RDATA   <= 32'h00000000;
            CFG_EXT_HIT <= 1'b0;
        end else begin
            CFG_ACK     <= CFG_IN.req;
            CFG_RDATA   <= cfg_rd ? rd_mux : 32'h00000000;
            CFG_EXT_HIT <= CFG_IN.req & hit_ext;
        end
    end

    // ****************************************************************
    // primary latency timer
    // ****************************************************************
    cbh_pkg::cbh_lat_state_t lat_state_reg;
    cbh_pkg::cbh_lat_state_t lat_state_next;
    logic [7:0]              lat_cnt_reg;
    logic [7:0]              lat_cnt_next;

    always_comb begin
        lat_state_next = lat_state_reg;
        lat_cnt_next   = lat_cnt_reg;
        if (INIT_FRAME_START) begin
            lat_state_next = cbh_pkg::CBH_LAT_COUNT;
            lat_cnt_next   = 8'h00;
        end else begin
            unique case (lat_state_reg)
                cbh_pkg::CBH_LAT_IDLE: begin
                    lat_cnt_next = 8'h00;
                end
                cbh_pkg::CBH_LAT_COUNT: begin
                    if (!INIT_XFER_ACTIVE) begin
                        lat_state_next = cbh_pkg::CBH_LAT_IDLE;
                    end else if (lat_cnt_reg == latency_reg) begin
                        lat_state_next = cbh_pkg::CBH_LAT_EXPIRED;
                    end else begin
                        lat_cnt_next = lat_cnt_reg + 8'h01;
                    end
                end
                cbh_pkg::CBH_LAT_EXPIRED: begin
                    if (!INIT_XFER_ACTIVE) begin
                        lat_state_next = cbh_pkg::CBH_LAT_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lat_state_reg <= cbh_pkg::CBH_LAT_IDLE;
            lat_cnt_reg   <= 8'h00;
        end else begin
            lat_state_reg <= lat_state_next;
            lat_cnt_reg   <= lat_cnt_next;
        end
    end

    logic lat_expired_now;
    logic terminate_next;

    assign lat_expired_now = (lat_state_reg == cbh_pkg::CBH_LAT_EXPIRED);
    assign terminate_next  = lat_expired_now & INIT_XFER_ACTIVE
                             & ~INIT_FRAME_START & gnt_deasserted;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LAT_EXPIRED    <= 1'b0;
            INIT_TERMINATE <= 1'b0;
        end else begin
            LAT_EXPIRED    <= lat_expired_now;
            INIT_TERMINATE <= terminate_next;
        end
    end

    // ****************************************************************
    // socket window decode
    // ****************************************************************
    logic win_hit;
    logic win_legacy;

    assign win_hit    = MEM_VALID & (MEM_ADDR[31:12] == base_reg[31:12]);
    assign win_legacy = (MEM_ADDR[11:0] >= `CBH_WIN_LEGACY_OFS);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SOCK_HIT   <= 1'b0;
            LEGACY_HIT <= 1'b0;
            WIN_OFFSET <= 11'h000;
        end else begin
            SOCK_HIT   <= win_hit & ~win_legacy;
            LEGACY_HIT <= win_hit & win_legacy;
            WIN_OFFSET <= MEM_ADDR[10:0];
        end
    end

endmodule : cbh_cfg_regs

/* testbench/cbh_cfg_chk.sv */
/*
 * port checker for the card bridge header slice.
 * assumes binding to cbh_cfg_regs, one clock, active low async reset.
 */
`timescale 1ns/1ps

module cbh_cfg_chk (
    input wire logic                   SYS_CLK,
    input wire logic                   ARST_N,
    input wire cbh_pkg::cbh_cfg_req_t  CFG_IN,
    input wire cbh_pkg::cbh_card_evt_t CARD_EVT,
    input wire logic                   INIT_FRAME_START,
    input wire logic                   INIT_XFER_ACTIVE,
    input wire logic                   PARITY_RESP_EN,
    input wire logic                   MEM_VALID,
    input wire logic [31:0]            MEM_ADDR,
    input wire logic                   CFG_ACK,
    input wire logic [31:0]            CFG_RDATA,
    input wire logic                   CFG_EXT_HIT,
    input wire logic                   LAT_EXPIRED,
    input wire logic                   INIT_TERMINATE,
    input wire logic                   SOCK_HIT,
    input wire logic                   LEGACY_HIT,
    input wire logic [10:0]            WIN_OFFSET
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    // ****************************************************************
    // read decodes
    // ****************************************************************
    wire rd_0c = CFG_IN.req && !CFG_IN.we && CFG_IN.addr[7:2] == 6'h03;
    wire rd_10 = CFG_IN.req && !CFG_IN.we && CFG_IN.addr[7:2] == 6'h04;
    wire rd_14 = CFG_IN.req && !CFG_IN.we && CFG_IN.addr[7:2] == 6'h05;

    a_ext_flag: assert property (
        CFG_IN.req |=> CFG_ACK && CFG_EXT_HIT == $past(CFG_IN.addr[7]))
        else $error("ext area flag wrong");
    a_hdr_fixed: assert property (
        rd_0c |=> CFG_RDATA[31:16] == 16'h0082)
        else $error("header or self-test byte wrong");
    a_base_align: assert property (
        rd_10 |=> CFG_RDATA[11:0] == 12'h000)
        else $error("base low bits not zero");
    a_cap_const: assert property (
        rd_14 |=> CFG_RDATA[15:0] == 16'h00a0)
        else $error("capability pointer wrong");
    a_status_fixed: assert property (
        rd_14 |=> CFG_RDATA[26:25] == 2'h1 && CFG_RDATA[23:16] == 8'h00)
        else $error("fixed status bits wrong");
    a_parity_flag: assert property (
        (CARD_EVT.addr_perr || CARD_EVT.data_perr) ##1 rd_14 |=> CFG_RDATA[31])
        else $error("parity flag not set");
    a_abort_flag: assert property (
        CARD_EVT.master_abort ##1 rd_14 |=> CFG_RDATA[29])
        else $error("master abort flag not set");
    a_tarx_flag: assert property (
        CARD_EVT.target_abort_rx ##1 rd_14 |=> CFG_RDATA[28])
        else $error("received target abort flag not set");
    a_dpar_flag: assert property (
        CARD_EVT.cperr && CARD_EVT.master_dphase && PARITY_RESP_EN ##1 rd_14
        |=> CFG_RDATA[24])
        else $error("data parity flag not set");
    a_win_offset: assert property (
        MEM_VALID |=> WIN_OFFSET == $past(MEM_ADDR[10:0]))
        else $error("window offset wrong");
    a_win_split: assert property (
        LEGACY_HIT |-> $past(MEM_ADDR[11]) && !SOCK_HIT)
        else $error("legacy hit below 800h");
    a_term_cause: assert property (
        INIT_TERMINATE |-> LAT_EXPIRED && $past(INIT_XFER_ACTIVE))
        else $error("terminate without expiry");
    a_lat_start: assert property (
        $rose(LAT_EXPIRED) |-> !$past(INIT_FRAME_START) && !$past(INIT_FRAME_START, 2))
        else $error("latency expired too early");
endmodule : cbh_cfg_chk

bind cbh_cfg_regs cbh_cfg_chk i_cbh_cfg_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CFG_IN(CFG_IN),
    .CARD_EVT(CARD_EVT), .INIT_FRAME_START(INIT_FRAME_START), .INIT_XFER_ACTIVE(INIT_XFER_ACTIVE),
    .PARITY_RESP_EN(PARITY_RESP_EN), .MEM_VALID(MEM_VALID), .MEM_ADDR(MEM_ADDR), .CFG_ACK(CFG_ACK),
    .CFG_RDATA(CFG_RDATA), .CFG_EXT_HIT(CFG_EXT_HIT), .LAT_EXPIRED(LAT_EXPIRED),
    .INIT_TERMINATE(INIT_TERMINATE), .SOCK_HIT(SOCK_HIT), .LEGACY_HIT(LEGACY_HIT),
    .WIN_OFFSET(WIN_OFFSET));

/* testbench/cbh_card_model.sv */
/*
 * far side model: card system error pin and bus grant pin.
 * assumes the bench commands it on the rising clock edge.
 */
`timescale 1ns/1ps

module cbh_card_model (
    input  wire logic       sys_clk,
    input  wire logic       serr_req,
    input  wire logic [1:0] serr_len,
    input  wire logic       grant_on,
    output logic            cserr_n,
    output logic            gnt_n
);
    logic [1:0] serr_cnt_reg;

    initial begin
        serr_cnt_reg = 2'h0;
        gnt_n        = 1'b1;
        forever begin
            @(posedge sys_clk);
            if (serr_req) begin
                serr_cnt_reg <= serr_len;
            end else if (serr_cnt_reg != 2'h0) begin
                serr_cnt_reg <= serr_cnt_reg - 2'h1;
            end
            gnt_n <= !grant_on;
        end
    end
    // only the card pulls it low; pulled up otherwise
    assign cserr_n = (serr_cnt_reg == 2'h0);
endmodule : cbh_card_model

/* testbench/tb.sv */
/*
 * self-checking bench for cbh_cfg_regs.
 * assumes the checker is bound and the card model stands beside it.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    end \
end

module tb;
    logic                   clk, arst_n, frame_start, xfer_active, par_en, mem_valid;
    logic                   serr_req, grant_on, cserr_n, gnt_n, ack, ext, lat_exp, term, s_hit, l_hit;
    logic [31:0]            mem_addr, rdata, rd_data;
    logic [10:0]            win_ofs;
    logic                   ext_hit;
    cbh_pkg::cbh_cfg_req_t  cfg_in;
    cbh_pkg::cbh_card_evt_t card_evt;
    int                     fail_count, comparisons;

    cbh_cfg_regs i_cbh_cfg_regs (.SYS_CLK(clk), .ARST_N(arst_n), .CFG_IN(cfg_in),
        .CARD_EVT(card_evt), .CSERR_N(cserr_n), .GNT_N(gnt_n), .INIT_FRAME_START(frame_start),
        .INIT_XFER_ACTIVE(xfer_active), .PARITY_RESP_EN(par_en), .MEM_VALID(mem_valid),
        .MEM_ADDR(mem_addr), .CFG_ACK(ack), .CFG_RDATA(rdata), .CFG_EXT_HIT(ext),
        .LAT_EXPIRED(lat_exp), .INIT_TERMINATE(term), .SOCK_HIT(s_hit), .LEGACY_HIT(l_hit),
        .WIN_OFFSET(win_ofs));
    cbh_card_model i_cbh_card_model (.sys_clk(clk), .serr_req(serr_req), .serr_len(2'h2),
        .grant_on(grant_on), .cserr_n(cserr_n), .gnt_n(gnt_n));

    // ****************************************************************
    // bus helpers
    // ****************************************************************
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        @(posedge clk);
        cfg_in <= '{req: 1'b1, we: w, addr: a, be: b, wdata: d};
        @(posedge clk);
        cfg_in.req <= 1'b0;
        #1;
        `CHK(ack, 1'b1)
        rd_data = rdata;
        ext_hit = ext;
    endtask : cfg

    task automatic mem_probe(input logic [31:0] a, input logic s, input logic l);
        @(posedge clk);
        mem_valid <= 1'b1;
        mem_addr <= a;
        @(posedge clk);
        mem_valid <= 1'b0;
        #1;
        `CHK({s_hit, l_hit}, {s, l})
        if (s || l) `CHK(win_ofs, a[10:0])
    endtask : mem_probe

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_fixed;
        cfg(1'b0, 8'h0c, 4'hf, 32'h0);
        `CHK(rd_data, 32'h0082_0000)
        cfg(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
        cfg(1'b0, 8'h0c, 4'hf, 32'h0);
        `CHK(rd_data, 32'h0082_ff00)
        cfg(1'b1, 8'h14, 4'h3, 32'h0000_ffff);
        cfg(1'b0, 8'h14, 4'hf, 32'h0);
        `CHK(rd_data, 32'h0200_00a0)
        cfg(1'b0, 8'h80, 4'hf, 32'h0);
        `CHK({ext_hit, rd_data}, {1'b1, 32'h0})
        cfg(1'b0, 8'h7c, 4'hf, 32'h0);
        `CHK(ext_hit, 1'b0)
        $display("t_fixed done");
    endtask : t_fixed

    task automatic t_base;
        cfg(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
        cfg(1'b0, 8'h10, 4'hf, 32'h0);
        `CHK(rd_data, 32'hffff_f000)
        cfg(1'b1, 8'h10, 4'hf, 32'h4000_0abc);
        cfg(1'b0, 8'h10, 4'hf, 32'h0);
        `CHK(rd_data, 32'h4000_0000)
        mem_probe(32'h4000_0123, 1'b1, 1'b0);
        mem_probe(32'h4000_0a55, 1'b0, 1'b1);
        mem_probe(32'h4000_1000, 1'b0, 1'b0);
        $display("t_base done");
    endtask : t_base

    task automatic t_status;
        logic [6:0]  ev [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h03, 7'h03};
        logic [15:0] ex [8] = '{16'h8000, 16'h8000, 16'h2000, 16'h1000, 16'h0800, 16'h0, 16'h0,
                                16'h0100};
        logic        pe [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            par_en <= pe[i];
            card_evt <= ev[i];
            // read in the very next cycle, so the flag checks see event then read
            fork
                begin
                    @(posedge clk);
                    card_evt <= '0;
                end
                cfg(1'b0, 8'h14, 4'hf, 32'h0);
            join
            `CHK(rd_data[31:16], 16'h0200 | ex[i])
            cfg(1'b1, 8'h14, 4'hc, 32'h0);
            cfg(1'b0, 8'h14, 4'hf, 32'h0);
            `CHK(rd_data[31:16], 16'h0200 | ex[i])
            cfg(1'b1, 8'h14, 4'hc, 32'hffff_0000);
            cfg(1'b0, 8'h14, 4'hf, 32'h0);
            `CHK(rd_data[31:16], 16'h0200)
        end
        @(posedge clk);
        serr_req <= 1'b1;
        @(posedge clk);
        serr_req <= 1'b0;
        repeat (8) @(posedge clk);
        cfg(1'b0, 8'h14, 4'hf, 32'h0);
        `CHK(rd_data[31:16], 16'h4200)
        cfg(1'b1, 8'h14, 4'hc, 32'h4000_0000);
        cfg(1'b0, 8'h14, 4'hf, 32'h0);
        `CHK(rd_data[31:16], 16'h0200)
        $display("t_status done");
    endtask : t_status

    task automatic t_latency;
        cfg(1'b1, 8'h0c, 4'h2, 32'h0000_0200);
        @(posedge clk);
        grant_on <= 1'b1;
        repeat (6) @(posedge clk);
        frame_start <= 1'b1;
        xfer_active <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(lat_exp, 1'b0)
        @(posedge clk);
        #1;
        `CHK({lat_exp, term}, 2'b10)
        @(posedge clk);
        grant_on <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (term === 1'b1) break;
        end
        `CHK(term, 1'b1)
        @(posedge clk);
        xfer_active <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK({lat_exp, term}, 2'b00)
        $display("t_latency done");
    endtask : t_latency

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #100us;
        fail_count++;
        end_sim();
    end

    initial begin
        arst_n = 1'b0;
        cfg_in = '0;
        card_evt = '0;
        {frame_start, xfer_active, par_en, mem_valid, serr_req, grant_on} = 6'h0;
        mem_addr = 32'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_fixed();
        t_base();
        t_status();
        t_latency();
        end_sim();
    end
endmodule : tb
